/* File: include/hot_swap_startup_sequencer_map.svh */
// timing constants support for the start-up sequencer
`ifndef HOT_SWAP_STARTUP_SEQUENCER_MAP_SVH
`define HOT_SWAP_STARTUP_SEQUENCER_MAP_SVH

// ****************************************
// timing
// ****************************************
`define HSS_CLK_HZ 20000000
`define HSS_TIMER_PERIOD_US 6200
`define HSS_TIMER_CYCLES ((`HSS_TIMER_PERIOD_US * (`HSS_CLK_HZ / 1000000)))
`define HSS_GLITCH_SHALLOW_US 20
`define HSS_GLITCH_SHALLOW_CYCLES ((`HSS_GLITCH_SHALLOW_US * (`HSS_CLK_HZ / 1000000)))
`define HSS_GLITCH_DEEP_US 2
`define HSS_GLITCH_DEEP_CYCLES ((`HSS_GLITCH_DEEP_US * (`HSS_CLK_HZ / 1000000)))
`define HSS_TIMER_DISCHARGE_CYCLES 4

`endif

/* File: include/hot_swap_startup_sequencer_pkg.sv */
// types for the start-up sequencer
package hot_swap_startup_sequencer_pkg;

    typedef enum logic [2:0] {
        ST_LOCKOUT,
        ST_WAIT_ENABLE,
        ST_GATE_CHECK,
        ST_FIRST_TIMING,
        ST_DISCHARGE,
        ST_PRESTART_CHECK,
        ST_SOFT_START,
        ST_RUN
    } seq_state_type;

    typedef struct packed {
        logic supply_ok;
        logic enable_high;
        logic enable_low;
        logic feedback_low;
        logic feedback_high;
        logic feedback_deep_low;
        logic gate_off;
        logic filter_low;
        logic fault_high;
    } comparator_type;

    typedef struct packed {
        logic gate_enable;
        logic gate_pull_down;
        logic timer_charge;
        logic timer_discharge_switch;
        logic filter_pull_down;
        logic reset_oe_b;
        logic soft_start_active;
    } drive_type;

endpackage

/* File: verilog/hot_swap_startup_sequencer.sv */
// start-up, supervision and system reset sequencer of a hot swap controller
`include "hot_swap_startup_sequencer_map.svh"

module hot_swap_startup_sequencer #(
    parameter int TIMER_CYCLES = `HSS_TIMER_CYCLES,
    parameter int GLITCH_SHALLOW_CYCLES = `HSS_GLITCH_SHALLOW_CYCLES,
    parameter int GLITCH_DEEP_CYCLES = `HSS_GLITCH_DEEP_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // comparator decisions from the analog front end
    input wire hot_swap_startup_sequencer_pkg::comparator_type cmp_i,
    // drive outputs
    output hot_swap_startup_sequencer_pkg::drive_type drive_o,
    output logic system_reset_b_o,
    output logic lockout_o,
    output logic power_good_o,
    output hot_swap_startup_sequencer_pkg::seq_state_type state_o
);
    import hot_swap_startup_sequencer_pkg::*;

    localparam int TW = $clog2(TIMER_CYCLES + 1);
    localparam int GW = $clog2(GLITCH_SHALLOW_CYCLES + 1);

    // ****************************************
    // parameter checks
    // ****************************************
    if (TIMER_CYCLES < 2 || GLITCH_DEEP_CYCLES < 1 ||
        GLITCH_SHALLOW_CYCLES < GLITCH_DEEP_CYCLES) begin : g_bad_timing
        $error("hot_swap_startup_sequencer: bad timing parameters");
    end
    if (`HSS_TIMER_DISCHARGE_CYCLES < 1 ||
        `HSS_TIMER_DISCHARGE_CYCLES > 8) begin : g_bad_discharge
        $error("hot_swap_startup_sequencer: discharge count must fit three bits");
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    comparator_type meta_q;
    comparator_type cmp_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            cmp_q <= '0;
        end else begin
            meta_q <= cmp_i;
            cmp_q <= meta_q;
        end
    end

    // ****************************************
    // sequencer state
    // ****************************************
    seq_state_type state_q;
    seq_state_type state_d;
    logic [TW-1:0] timer_q;
    logic [TW-1:0] timer_d;
    logic [2:0] dis_q;
    logic [2:0] dis_d;
    logic ext_lock_q;
    logic ext_lock_d;
    logic enable_q;
    logic enable_d;

    // enable hysteresis: set above high level, clear below low level
    wire enable_set = cmp_q.enable_high;
    wire enable_clear = cmp_q.enable_low;
    assign enable_d = enable_set ? 1'b1 : (enable_clear ? 1'b0 : enable_q);

    wire supply_bad = !cmp_q.supply_ok;
    wire enable_off = !enable_q;
    wire timer_done = (timer_q == TW'(TIMER_CYCLES - 1));
    wire timer_running = (state_q == ST_FIRST_TIMING) || (state_q == ST_SOFT_START);
    wire discharge_done = (dis_q == 3'(`HSS_TIMER_DISCHARGE_CYCLES - 1));
    wire gate_is_off = cmp_q.gate_off;
    wire prestart_ok = cmp_q.filter_low && cmp_q.fault_high;
    wire trip_low = !cmp_q.fault_high;
    wire may_start = enable_q && !ext_lock_q;

    always_comb begin
        state_d = state_q;
        timer_d = '0;
        dis_d = '0;
        ext_lock_d = ext_lock_q;
        if (supply_bad) begin
            state_d = ST_LOCKOUT;
            ext_lock_d = 1'b0;
        end else if (enable_off && state_q != ST_LOCKOUT) begin
            state_d = ST_WAIT_ENABLE;
            ext_lock_d = 1'b0;
        end else begin
            case (state_q)
                ST_LOCKOUT: begin
                    if (enable_d) begin
                        state_d = ST_GATE_CHECK;
                    end else begin
                        state_d = ST_WAIT_ENABLE;
                    end
                end
                ST_WAIT_ENABLE: begin
                    if (may_start) begin
                        state_d = ST_GATE_CHECK;
                    end
                end
                ST_GATE_CHECK: begin
                    if (gate_is_off) begin
                        state_d = ST_FIRST_TIMING;
                    end
                end
                ST_FIRST_TIMING: begin
                    timer_d = timer_q + TW'(1);
                    if (timer_done) begin
                        timer_d = '0;
                        state_d = ST_DISCHARGE;
                    end
                end
                ST_DISCHARGE: begin
                    dis_d = dis_q + 3'd1;
                    if (discharge_done) begin
                        state_d = ST_PRESTART_CHECK;
                    end
                end
                ST_PRESTART_CHECK: begin
                    if (prestart_ok) begin
                        state_d = ST_SOFT_START;
                    end
                end
                ST_SOFT_START: begin
                    timer_d = timer_q + TW'(1);
                    if (timer_done) begin
                        timer_d = '0;
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (trip_low) begin
                        ext_lock_d = 1'b1;
                        state_d = ST_WAIT_ENABLE;
                    end
                end
                default: state_d = ST_LOCKOUT;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_LOCKOUT;
            timer_q <= '0;
            dis_q <= '0;
            ext_lock_q <= 1'b0;
            enable_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            dis_q <= dis_d;
            ext_lock_q <= ext_lock_d;
            enable_q <= enable_d;
        end
    end

    // ****************************************
    // feedback glitch filter
    // ****************************************
    logic [GW-1:0] glitch_q;
    logic fb_bad_q;
    wire fb_low_now = cmp_q.feedback_low;
    wire [GW-1:0] glitch_limit = cmp_q.feedback_deep_low ?
        GW'(GLITCH_DEEP_CYCLES - 1) : GW'(GLITCH_SHALLOW_CYCLES - 1);
    wire fb_clear = cmp_q.feedback_high;
    wire glitch_expired = (glitch_q >= glitch_limit);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            glitch_q <= '0;
            fb_bad_q <= 1'b1;
        end else if (!fb_low_now) begin
            glitch_q <= '0;
            if (fb_clear) begin
                fb_bad_q <= 1'b0;
            end
        end else if (glitch_expired) begin
            fb_bad_q <= 1'b1;
        end else begin
            glitch_q <= glitch_q + GW'(1);
        end
    end

    // ****************************************
    // power-good timing cycle
    // ****************************************
    logic [TW-1:0] good_q;
    logic good_q_done;
    logic release_q;
    wire pg_timing = (state_q == ST_RUN) && !fb_bad_q;
    wire good_full = (good_q == TW'(TIMER_CYCLES - 1));
    wire good_count_en = !good_q_done;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            good_q <= '0;
            good_q_done <= 1'b0;
        end else if (!pg_timing) begin
            good_q <= '0;
            good_q_done <= 1'b0;
        end else if (good_full) begin
            good_q_done <= 1'b1;
        end else if (good_count_en) begin
            good_q <= good_q + TW'(1);
        end
    end

    // ****************************************
    // system reset release
    // ****************************************
    logic released_once_q;
    logic released_once_d;
    logic release_d;
    wire run_now = (state_q == ST_RUN);
    wire run_next = (state_d == ST_RUN);
    wire hold_reset = !run_now || !run_next || fb_bad_q;
    wire first_release = !released_once_q && cmp_q.feedback_high;

    // first release at soft-start end, later releases after a full cycle
    always_comb begin
        release_d = release_q;
        released_once_d = released_once_q;
        if (hold_reset) begin
            release_d = 1'b0;
            if (!run_now) begin
                released_once_d = 1'b0;
            end
        end else if (first_release) begin
            release_d = 1'b1;
            released_once_d = 1'b1;
        end else if (good_q_done) begin
            release_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            released_once_q <= 1'b0;
            release_q <= 1'b0;
        end else begin
            released_once_q <= released_once_d;
            release_q <= release_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    wire gate_on = (state_q == ST_SOFT_START) || (state_q == ST_RUN);
    wire in_soft_start = (state_q == ST_SOFT_START);
    wire in_lockout = (state_q == ST_LOCKOUT);
    wire timer_idle = !timer_running;
    drive_type drive_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drive_q <= '{gate_enable: 1'b0, gate_pull_down: 1'b1, timer_charge: 1'b0,
                timer_discharge_switch: 1'b1, filter_pull_down: 1'b1,
                reset_oe_b: 1'b0, soft_start_active: 1'b0};
        end else begin
            drive_q.gate_enable <= gate_on;
            drive_q.gate_pull_down <= !gate_on;
            drive_q.timer_charge <= timer_running;
            drive_q.timer_discharge_switch <= timer_idle;
            drive_q.filter_pull_down <= !gate_on;
            drive_q.reset_oe_b <= release_d;
            drive_q.soft_start_active <= in_soft_start;
        end
    end

    assign drive_o = drive_q;
    assign system_reset_b_o = release_q;
    assign lockout_o = in_lockout;
    assign power_good_o = !fb_bad_q;
    assign state_o = state_q;

endmodule

/* File: bench/hot_swap_startup_sequencer_props.sv */
// port checker for the start-up sequencer
module hot_swap_startup_sequencer_props
    import hot_swap_startup_sequencer_pkg::*;
#(
    parameter int TIMER_CYCLES = 16
) (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire hot_swap_startup_sequencer_pkg::comparator_type cmp_i,
    input wire hot_swap_startup_sequencer_pkg::drive_type drive_o,
    input wire logic system_reset_b_o,
    input wire logic lockout_o,
    input wire logic power_good_o,
    input wire hot_swap_startup_sequencer_pkg::seq_state_type state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // cycles spent in a timing state
    wire timing = state_o == ST_FIRST_TIMING || state_o == ST_SOFT_START;
    int cnt_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) cnt_q <= 0;
        else cnt_q <= timing ? cnt_q + 1 : 0;
    end
    chk_lock_reset: assert property (lockout_o |-> !system_reset_b_o)
        else $error("reset released in lockout");
    chk_lock_gate: assert property (lockout_o && $past(lockout_o) |->
        drive_o.gate_pull_down && !drive_o.gate_enable) else $error("gate on in lockout");
    chk_supply_loss: assert property (!cmp_i.supply_ok [*6] |-> lockout_o)
        else $error("no lockout on supply loss");
    chk_timer_idle: assert property (!timing && !$past(timing) |->
        drive_o.timer_discharge_switch && !drive_o.timer_charge)
        else $error("timer node left floating");
    chk_gate_first: assert property (state_o == ST_FIRST_TIMING &&
        $past(state_o) != ST_FIRST_TIMING |-> $past(state_o) == ST_GATE_CHECK)
        else $error("timing began without gate check");
    chk_timer_len: assert property (state_o == ST_DISCHARGE &&
        $past(state_o) == ST_FIRST_TIMING || state_o == ST_RUN &&
        $past(state_o) == ST_SOFT_START |-> cnt_q == TIMER_CYCLES)
        else $error("timing period length wrong");
    chk_discharge_len: assert property ($rose(state_o == ST_DISCHARGE) |->
        (state_o == ST_DISCHARGE) [*4] ##1 state_o == ST_PRESTART_CHECK)
        else $error("discharge phase length wrong");
    chk_prestart_hold: assert property ((state_o == ST_PRESTART_CHECK &&
        !cmp_i.fault_high) [*4] |=> state_o != ST_SOFT_START)
        else $error("soft start with trip input low");
    chk_release_run: assert property ($rose(system_reset_b_o) |->
        state_o == ST_RUN && power_good_o) else $error("reset released early");
    chk_glitch_hold: assert property (cmp_i.feedback_low [*8] |->
        ##[0:8] !system_reset_b_o) else $error("reset kept high on low feedback");
    chk_enable_off: assert property (cmp_i.enable_low [*7] |->
        drive_o.gate_pull_down) else $error("gate not pulled with enable low");
endmodule

/* File: bench/backplane_model.sv */
// backplane supply, pass transistor and load seen as comparator levels
module backplane_model
    import hot_swap_startup_sequencer_pkg::*;
(
    // bench controls
    input wire logic clk_i,
    input wire logic supply_i,
    input wire logic enable_i,
    input wire logic fault_i,
    input wire logic dip_i,
    input wire logic deep_i,
    // device side
    input wire hot_swap_startup_sequencer_pkg::drive_type drive_i,
    output hot_swap_startup_sequencer_pkg::comparator_type cmp_o
);
    logic [3:0] vout_q = 4'h0;
    // load charges while the gate drives and bleeds off otherwise
    always @(posedge clk_i) begin
        if (drive_i.gate_enable && vout_q != 4'hf) vout_q <= vout_q + 4'h1;
        else if (!drive_i.gate_enable && vout_q != 4'h0) vout_q <= vout_q - 4'h1;
    end
    wire fb_good = vout_q > 4'h9 && !dip_i && !deep_i;
    assign cmp_o = '{supply_ok: supply_i, enable_high: enable_i, enable_low: !enable_i,
        feedback_low: !fb_good, feedback_high: fb_good, feedback_deep_low: deep_i,
        gate_off: vout_q == 4'h0, filter_low: 1'b1, fault_high: fault_i};
endmodule

/* File: bench/hot_swap_startup_sequencer_bench.sv */
// self-checking bench of the start-up sequencer
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module hot_swap_startup_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import hot_swap_startup_sequencer_pkg::*;
    logic clk_i = 0, rst_b_i = 0, supply = 0, enable = 0, fault = 1, dip = 0, deep = 0;
    comparator_type cmp;
    drive_type drive;
    logic sys_rst_b, lockout, pg;
    seq_state_type state;
    int mismatches = 0, num_checks = 0, cycles = 0;
    always #25 clk_i = ~clk_i;
    backplane_model load (.clk_i(clk_i), .supply_i(supply), .enable_i(enable),
        .fault_i(fault), .dip_i(dip), .deep_i(deep), .drive_i(drive), .cmp_o(cmp));
    hot_swap_startup_sequencer #(.TIMER_CYCLES(16), .GLITCH_SHALLOW_CYCLES(8),
        .GLITCH_DEEP_CYCLES(2)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmp_i(cmp),
        .drive_o(drive), .system_reset_b_o(sys_rst_b), .lockout_o(lockout),
        .power_good_o(pg), .state_o(state));
    task complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    task tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task wait_rst(input logic want);
        for (int i = 0; i < 150 && sys_rst_b !== want; i++) tick(1);
        `CHK(sys_rst_b, want)
    endtask
    task t_startup();
        supply = 0; enable = 1; tick(10);
        `CHK(lockout, 1'b1)
        `CHK(sys_rst_b, 1'b0)
        supply = 1; enable = 0; tick(10);
        `CHK(drive.timer_charge, 1'b0)
        `CHK(drive.timer_discharge_switch, 1'b1)
        `CHK(drive.filter_pull_down, 1'b1)
        enable = 1; wait_rst(1'b1);
        `CHK(state, ST_RUN)
        `CHK(pg, 1'b1)
        $display("startup done");
    endtask
    task t_glitch();
        dip = 1; tick(2); dip = 0; tick(20);
        `CHK(sys_rst_b, 1'b1)
        deep = 1; tick(6); deep = 0; wait_rst(1'b0);
        wait_rst(1'b1);
        dip = 1; tick(20);
        `CHK(sys_rst_b, 1'b0)
        `CHK(pg, 1'b0)
        dip = 0; tick(10);
        `CHK(sys_rst_b, 1'b0)
        wait_rst(1'b1);
        $display("glitch done");
    endtask
    task t_fault();
        fault = 0; tick(60); fault = 1; tick(60);
        `CHK(sys_rst_b, 1'b0)
        `CHK(drive.gate_enable, 1'b0)
        enable = 0; tick(20);
        `CHK(drive.gate_pull_down, 1'b1)
        fault = 0; enable = 1; tick(80);
        `CHK(state, ST_PRESTART_CHECK)
        `CHK(drive.gate_enable, 1'b0)
        fault = 1;
        tick(6);
        `CHK(drive.soft_start_active, 1'b1)
        `CHK(drive.gate_enable, 1'b1)
        wait_rst(1'b1);
        tick(1);
        `CHK(drive.reset_oe_b, 1'b1)
        $display("fault done");
    endtask
    task t_supply();
        supply = 0; tick(10);
        `CHK(lockout, 1'b1)
        `CHK(drive.gate_pull_down, 1'b1)
        `CHK(sys_rst_b, 1'b0)
        supply = 1; wait_rst(1'b1);
        $display("supply done");
    endtask
    initial begin
        tick(8);
        rst_b_i = 1;
        t_startup();
        t_glitch();
        t_fault();
        t_supply();
        complete_run();
    end
endmodule
bind hot_swap_startup_sequencer hot_swap_startup_sequencer_props #(
    .TIMER_CYCLES(TIMER_CYCLES)) props (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmp_i(cmp_i),
    .drive_o(drive_o), .system_reset_b_o(system_reset_b_o), .lockout_o(lockout_o),
    .power_good_o(power_good_o), .state_o(state_o));
